/* testbench/audio_led_control_regs_bench.sv */
`timescale 1ns/1ns
module audio_led_control_regs_bench;
    logic                   clk_sys, reset_n, reg_write, audio_amp_valid;
    logic [7:0]             reg_addr, reg_wdata, reg_rdata, q;
    logic [3:0]             audio_amp, agc_level;
    logic                   audio_buf_en, precharge_en, agc_fast_decay, converter_500k_run;
    logic                   sink_group_a_sync, sink_group_b_sync;
    logic signed [7:0]      buffer_gain_db;
    logic [7:0]             sink_a0, sink_a1, sink_a2, sink_b0, sink_b1, sink_b2;
    audio_led_pkg::agc_mode_t agc_mode;
    int                     err_count = 0;
    int                     n_checks = 0;
    int                     fct [8] = '{1, 2, 4, 8, 12, 14, 15, 16};
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
    row_t rows [7] = '{'{8'h16, 8'hFF, 8'hDD}, '{8'h47, 8'hA5, 8'hA5},
        '{8'h49, 8'hFF, 8'h1F}, '{8'h20, 8'hFF, 8'h00}, '{8'h16, 8'h00, 8'h00},
        '{8'h47, 8'h00, 8'h00}, '{8'h49, 8'h00, 8'h00}};
    // Short hold and decay units keep the run brief
    audio_led_control_regs #(.HOLD_UNIT_CYCLES(20), .SLOW_DECAY_CYCLES(16),
        .FAST_DECAY_CYCLES(4)) audio_led_control_regs_inst (.clk_sys, .reset_n, .reg_addr,
        .reg_wdata, .reg_write, .reg_rdata, .audio_amp, .audio_amp_valid, .audio_buf_en,
        .precharge_en, .buffer_gain_db, .agc_mode, .agc_fast_decay, .agc_level,
        .converter_500k_run, .sink_group_a_sync, .sink_group_b_sync, .sink_a0, .sink_a1,
        .sink_a2, .sink_b0, .sink_b1, .sink_b2);
    audio_source audio_source_inst (.clk_sys, .audio_amp, .audio_amp_valid);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #5;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk_sys);
        #5;
        reg_write = 1'b0;
    endtask
    // Read data is registered, so hold the address two edges
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        repeat (2) @(posedge clk_sys);
        #5;
        q = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask
    task automatic sample(input logic [3:0] a);
        audio_source_inst.send(a);
        cyc(2);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog well beyond the expected run of under 10000 cycles
    initial begin
        #2000000;
        err_count++;
        $display("ERROR watchdog ran out");
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk("readback", rows[i].q, q);
        end
        $display("test register rows done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h47, {2'b00, 3'(i), 3'(i)});
            chk("gain", 8'hF4 + 8'(6 * i), buffer_gain_db);
            chk("fast decay", 8'((i >= 2) && (i % 2 == 1)), {7'h0, agc_fast_decay});
        end
        $display("test gain sweep done");
        wr(8'h47, 8'h00);
        wr(8'h49, 8'h0F);
        for (int c = 1; c < 8; c++) begin
            wr(8'h16, {3'b000, 3'(c), 2'b01});
            sample(4'hF);
            chk("red", c[2] ? 8'hFF : 8'h00, sink_b0);
            chk("green", c[1] ? 8'hFF : 8'h00, sink_b1);
            chk("blue", c[0] ? 8'hFF : 8'h00, sink_b2);
            chk("group a idle", 8'h00, sink_a0);
        end
        $display("test colour done");
        for (int k = 0; k < 8; k++) begin
            wr(8'h49, {5'b00001, 3'(k)});
            sample(4'hF);
            chk("amplitude", 8'(255 * fct[k] / 16), sink_b0);
        end
        wr(8'h49, 8'h17);
        sample(4'hF);
        chk("group a red", 8'hFF, sink_a0);
        chk("group a green", 8'hFF, sink_a1);
        chk("group a blue", 8'hFF, sink_a2);
        chk("converter", 8'h01, {7'h0, converter_500k_run});
        wr(8'h49, 8'h0F);
        sample(4'h1);
        chk("linear low", 8'h11, sink_b0);
        wr(8'h47, 8'h08);
        sample(4'h1);
        chk("low cut", 8'h00, sink_b0);
        sample(4'h2);
        chk("low cut pass", 8'h22, sink_b0);
        $display("test amplitude done");
        // Peak hold of two units: quieter sample ignored until it runs out
        wr(8'h47, 8'h00);
        wr(8'h16, 8'h91);
        sample(4'hF);
        cyc(20);
        sample(4'h3);
        chk("held peak", 8'hFF, sink_b0);
        cyc(25);
        sample(4'h3);
        chk("hold expired", 8'h33, sink_b0);
        // Four-unit hold outlasts the two-unit one
        wr(8'h16, 8'hD1);
        sample(4'hF);
        cyc(70);
        sample(4'h3);
        chk("long hold", 8'hFF, sink_b0);
        cyc(10);
        sample(4'h3);
        chk("long expired", 8'h33, sink_b0);
        $display("test persistence done");
        // Envelope: instant attack, one step down per decay period
        wr(8'h47, 8'h10);
        sample(4'h9);
        chk("level attack", 8'h09, {4'h0, agc_level});
        cyc(13);
        chk("slow decay wait", 8'h09, {4'h0, agc_level});
        cyc(1);
        chk("slow decay step", 8'h08, {4'h0, agc_level});
        wr(8'h47, 8'h00);
        cyc(1);
        chk("level off", 8'h00, {4'h0, agc_level});
        wr(8'h47, 8'h18);
        sample(4'hC);
        cyc(1);
        chk("fast decay wait", 8'h0C, {4'h0, agc_level});
        cyc(1);
        chk("fast decay step", 8'h0B, {4'h0, agc_level});
        // Lookup colour: full level is white, silence is black
        wr(8'h16, 8'h01);
        sample(4'hF);
        chk("lut white", 8'hFF, sink_b1);
        sample(4'h0);
        chk("lut black", 8'h00, sink_b0);
        $display("test envelope done");
        // Precharge: timed run, abort, manual and disabled
        wr(8'h16, 8'h00);
        wr(8'h16, 8'h01);
        cyc(5);
        chk("precharge start", 8'h01, {7'h0, precharge_en});
        cyc(2995);
        chk("precharge late", 8'h01, {7'h0, precharge_en});
        cyc(1);
        chk("precharge end", 8'h00, {7'h0, precharge_en});
        wr(8'h16, 8'h00);
        wr(8'h16, 8'h01);
        cyc(5);
        wr(8'h16, 8'h00);
        cyc(2);
        chk("precharge abort", 8'h00, {7'h0, precharge_en});
        wr(8'h47, 8'h40);
        wr(8'h16, 8'h01);
        cyc(3010);
        chk("manual precharge", 8'h01, {7'h0, precharge_en});
        wr(8'h16, 8'h00);
        wr(8'h47, 8'h80);
        wr(8'h16, 8'h01);
        cyc(5);
        chk("precharge disabled", 8'h00, {7'h0, precharge_en});
        $display("test precharge done");
        // Reset in mid-run restores every default
        wr(8'h49, 8'h1F);
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        rd(8'h16);
        chk("mode reset", 8'h00, q);
        rd(8'h47);
        chk("input reset", 8'h00, q);
        rd(8'h49);
        chk("output reset", 8'h00, q);
        chk("gain reset", 8'hF4, buffer_gain_db);
        $display("test reset done");
        finish_test();
    end
endmodule

/* testbench/audio_led_control_regs_monitor.sv */
`timescale 1ns/1ns
`include "audio_led_cfg.svh"
module audio_led_control_regs_monitor
    import audio_led_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_rdata,
    input wire logic        audio_buf_en,
    input wire logic        precharge_en,
    input wire logic signed [7:0] buffer_gain_db,
    input wire agc_mode_t   agc_mode,
    input wire logic        agc_fast_decay,
    input wire logic        converter_500k_run,
    input wire logic        sink_group_a_sync,
    input wire logic        sink_group_b_sync,
    input wire logic [7:0]  sink_b0,
    input wire logic [7:0]  sink_b1,
    input wire logic [7:0]  sink_b2
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Write decodes and expected field values
    wire       wr_mode  = reg_write && reg_addr == `MODE_REG_ADDR;
    wire       wr_in    = reg_write && reg_addr == `INPUT_REG_ADDR;
    wire       wr_out   = reg_write && reg_addr == `OUTPUT_REG_ADDR;
    wire       mapped   = reg_addr inside {`MODE_REG_ADDR, `INPUT_REG_ADDR, `OUTPUT_REG_ADDR};
    wire [2:0] agc_code = reg_wdata[5:3];
    wire [2:0] exp_mode = agc_code < 3'h2 ? agc_code : (agc_code >> 1) + 3'h1;
    wire       exp_fast = agc_code[0] && agc_code[2:1] != 2'b00;
    wire [7:0] exp_gain = 8'hF4 + 8'(reg_wdata[2:0]) * 8'h06;
    ////////////////////////////////////////////////////////////////////////////
    buf_on_a: assert property (wr_mode |=> audio_buf_en == $past(reg_wdata[0]))
        else $error("buffer enable does not follow mode write");
    gain_step_a: assert property (wr_in |=> $unsigned(buffer_gain_db) == $past(exp_gain))
        else $error("buffer gain wrong for code");
    agc_sel_a: assert property (wr_in |=> agc_mode == agc_mode_t'($past(exp_mode)))
        else $error("gain control mode wrong for code");
    decay_sel_a: assert property (wr_in |=> agc_fast_decay == $past(exp_fast))
        else $error("decay speed wrong for code");
    man_start_a: assert property (wr_in && reg_wdata[7:6] == 2'b01
        |=> precharge_en == audio_buf_en)
        else $error("manual precharge not tied to buffer enable");
    dis_start_a: assert property (wr_in && reg_wdata[7] |=> !precharge_en)
        else $error("precharge seen while disabled");
    sync_bits_a: assert property (wr_out
        |=> {sink_group_a_sync, sink_group_b_sync} == $past(reg_wdata[4:3]))
        else $error("sync enables do not follow output write");
    conv_run_a: assert property (
        converter_500k_run == (sink_group_a_sync || sink_group_b_sync))
        else $error("converter run not the or of the sync enables");
    group_off_a: assert property (!sink_group_b_sync [*3] |-> {sink_b0, sink_b1, sink_b2} == 24'h0)
        else $error("group b sinks lit with sync off");
    unmapped_a: assert property (!mapped |=> reg_rdata == 8'h00)
        else $error("unmapped address reads nonzero");
    mode_back_a: assert property (wr_mode ##1 (reg_addr == `MODE_REG_ADDR && !reg_write)
        |=> reg_rdata == ($past(reg_wdata, 2) & `MODE_REG_WMASK))
        else $error("mode readback wrong");
    // Main scenarios reached
    cover property ($rose(precharge_en));
    cover property (sink_b0 == 8'hFF);
    cover property (agc_fast_decay);
endmodule
bind audio_led_control_regs audio_led_control_regs_monitor mon_inst (.clk_sys, .reset_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_rdata, .audio_buf_en, .precharge_en,
    .buffer_gain_db, .agc_mode, .agc_fast_decay, .converter_500k_run, .sink_group_a_sync,
    .sink_group_b_sync, .sink_b0, .sink_b1, .sink_b2);

/* testbench/audio_source.sv */
`timescale 1ns/1ns
// Stand-in for the converter feeding amplitude samples
module audio_source (
    input  wire logic       clk_sys,
    output logic      [3:0] audio_amp,
    output logic            audio_amp_valid
);
    initial begin
        audio_amp = 4'h0;
        audio_amp_valid = 1'b0;
    end
    // One strobed sample; the bus shows garbage once the strobe drops
    task automatic send(input logic [3:0] a);
        @(posedge clk_sys);
        #5;
        audio_amp = a;
        audio_amp_valid = 1'b1;
        @(posedge clk_sys);
        #5;
        audio_amp_valid = 1'b0;
        audio_amp = ~a;
    endtask
endmodule

/* verilog/agc_envelope.sv */
`timescale 1ns/1ns
`include "audio_led_cfg.svh"
module agc_envelope #(
    parameter int SLOW_DECAY_CYCLES = `SLOW_DECAY_MS * `CLK_KHZ,
    parameter int FAST_DECAY_CYCLES = `FAST_DECAY_MS * `CLK_KHZ
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    agc_if.follower   agc
);
    logic [19:0] decay_cnt;
    logic [3:0]  level;
    wire  [19:0] decay_len  = agc.fast_decay ? FAST_DECAY_CYCLES[19:0] : SLOW_DECAY_CYCLES[19:0];
    wire         attack     = agc.sample_valid && (agc.sample > level);
    wire         decay_tick = (decay_cnt >= decay_len - 20'h00001);

    assign agc.level = level;

    ////////////////////////////////////////////////////////////////////////////
    // Fast attack, stepped decay on a 0..15 scale
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !agc.enable) begin
            level     <= 4'h0;
            decay_cnt <= 20'h00000;
        end else if (attack) begin
            level     <= agc.sample;                          // [RULE14]
            decay_cnt <= 20'h00000;
        end else if (decay_tick) begin
            level     <= (level != 4'h0) ? level - 4'h1 : 4'h0; // [RULE14]
            decay_cnt <= 20'h00000;
        end else begin
            decay_cnt <= decay_cnt + 20'h00001;
        end
    end
endmodule

/* verilog/agc_if.sv */
`timescale 1ns/1ns
interface agc_if;
    logic       sample_valid;
    logic [3:0] sample;
    logic       enable;
    logic       fast_decay;
    logic [3:0] level;

    modport owner    (output sample_valid, sample, enable, fast_decay, input level);
    modport follower (input sample_valid, sample, enable, fast_decay, output level);
endinterface

/* verilog/audio_led_cfg.svh */
`ifndef AUDIO_LED_CFG_SVH
`define AUDIO_LED_CFG_SVH

// Register offsets
`define MODE_REG_ADDR        8'h16
`define INPUT_REG_ADDR       8'h47
`define OUTPUT_REG_ADDR      8'h49

// Reset values
`define MODE_REG_RESET       8'h00
`define INPUT_REG_RESET      8'h00
`define OUTPUT_REG_RESET     8'h00

// Writable bits; undefined bits stay zero
`define MODE_REG_WMASK       8'hDD
`define INPUT_REG_WMASK      8'hFF
`define OUTPUT_REG_WMASK     8'h1F

// Field positions, audio_led_mode_control
`define BUF_ON_BIT           0
`define COLOR_LSB            2
`define COLOR_MSB            4
`define SPEED_LSB            6
`define SPEED_MSB            7

// Field positions, audio_input_control
`define GAIN_LSB             0
`define GAIN_MSB             2
`define AGC_LSB              3
`define AGC_MSB              5
`define MAN_START_BIT        6
`define DIS_START_BIT        7

// Field positions, audio_output_control
`define AMPL_LSB             0
`define AMPL_MSB             2
`define SYNC_B_BIT           3
`define SYNC_A_BIT           4

// Timing
`define CLK_KHZ              10000
`define PRECHARGE_US         300
`define PRECHARGE_CYCLES     ((`PRECHARGE_US * `CLK_KHZ) / 1000)
`define HOLD_UNIT_MS         200
`define SLOW_DECAY_MS        10
`define FAST_DECAY_MS        2

// Gain steps in dB
`define GAIN_BASE_DB         (-12)
`define GAIN_STEP_DB         6

// Low-amplitude cut level for the noise-suppression mode
`define LOW_CUT_LEVEL        4'h2

`endif

/* verilog/audio_led_control_regs.sv */
`timescale 1ns/1ns
`include "audio_led_cfg.svh"

// Operation
// RULE1 - Mode register bit 0 turns the audio input buffer on when one and off when zero, resetting to zero.
// RULE2 - Colour field 4:2 selects the lookup colour scheme at zero, else a fixed colour with bit 4 red, bit 3 green, bit 2 blue.
// RULE3 - Persistence field 7:6 holds the LED output for none, 200 ms, 400 ms or 800 ms.
// RULE4 - Gain field 2:0 of the input register sets buffer gain from -12 dB to +30 dB in 6 dB steps.
// RULE5 - Gain-control field 5:3 turns gain control off at 000 and only suppresses low amplitudes at 001.
// RULE6 - Gain-control codes 010 to 111 pick curve A, B or C in pairs, even code slow decay, odd code fast decay.
// RULE7 - With manual start clear and precharge allowed, the coupling capacitor precharges for 300 us at buffer startup.
// RULE8 - With manual start set, precharge runs continuously while the buffer enable is one; the code keeps precharge off when bit 7 is also set.
// RULE9 - Input register bit 7 set disables startup precharge completely.
// RULE10 - Master amplitude field scales output current to 6.25, 12.5, 25, 50, 75, 87.5, 93.75 or 100 percent.
// RULE11 - Output register bit 3 makes the three-sink group follow audio with the converter running at 500 kHz.
// RULE12 - Output register bit 4 makes the high-voltage group follow audio with the converter running at 500 kHz.
// RULE13 - Lookup colour mode maps low amplitude to black and rises through blue, green, cyan, yellow, red to white.
// RULE14 - The amplitude measurement is a 0..15 integer with short attack and a decay set by the gain-control field.
// RULE15 - Undefined register bits read as zero and ignore writes.
module audio_led_control_regs
    import audio_led_pkg::*;
#(
    parameter int HOLD_UNIT_CYCLES  = `HOLD_UNIT_MS * `CLK_KHZ,
    parameter int SLOW_DECAY_CYCLES = `SLOW_DECAY_MS * `CLK_KHZ,
    parameter int FAST_DECAY_CYCLES = `FAST_DECAY_MS * `CLK_KHZ
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    output logic      [7:0]  reg_rdata,
    input  wire logic [3:0]  audio_amp,
    input  wire logic        audio_amp_valid,
    output logic             audio_buf_en,
    output logic             precharge_en,
    output logic signed [7:0] buffer_gain_db,
    output agc_mode_t        agc_mode,
    output logic             agc_fast_decay,
    output logic      [3:0]  agc_level,
    output logic             converter_500k_run,
    output logic             sink_group_a_sync,
    output logic             sink_group_b_sync,
    output logic      [7:0]  sink_a0,
    output logic      [7:0]  sink_a1,
    output logic      [7:0]  sink_a2,
    output logic      [7:0]  sink_b0,
    output logic      [7:0]  sink_b1,
    output logic      [7:0]  sink_b2
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Amplitude factor in sixteenths
    function automatic logic [4:0] ampl_factor(input logic [2:0] code);
        case (code)
            3'h0:    ampl_factor = 5'h01;
            3'h1:    ampl_factor = 5'h02;
            3'h2:    ampl_factor = 5'h04;
            3'h3:    ampl_factor = 5'h08;
            3'h4:    ampl_factor = 5'h0C;
            3'h5:    ampl_factor = 5'h0E;
            3'h6:    ampl_factor = 5'h0F;
            default: ampl_factor = 5'h10;
        endcase
    endfunction

    function automatic logic [7:0] scale(input logic [7:0] v, input logic [2:0] code);
        logic [12:0] prod;
        prod  = v * ampl_factor(code);
        scale = prod[11:4];                                   // [RULE10]
    endfunction

    // Lookup colour ramp over the 0..15 level
    function automatic rgb_t lut_rgb(input logic [3:0] lvl);
        case (lvl)
            4'h0, 4'h1: lut_rgb = '{8'h00, 8'h00, 8'h00};
            4'h2:       lut_rgb = '{8'h00, 8'h00, 8'h80};
            4'h3:       lut_rgb = '{8'h00, 8'h00, 8'hFF};
            4'h4:       lut_rgb = '{8'h00, 8'h80, 8'h80};
            4'h5:       lut_rgb = '{8'h00, 8'hFF, 8'h00};
            4'h6:       lut_rgb = '{8'h00, 8'hFF, 8'h80};
            4'h7:       lut_rgb = '{8'h00, 8'hFF, 8'hFF};
            4'h8:       lut_rgb = '{8'h80, 8'hFF, 8'h80};
            4'h9:       lut_rgb = '{8'hFF, 8'hFF, 8'h00};
            4'hA:       lut_rgb = '{8'hFF, 8'h80, 8'h00};
            4'hB:       lut_rgb = '{8'hFF, 8'h00, 8'h00};
            4'hC:       lut_rgb = '{8'hFF, 8'h40, 8'h40};
            4'hD:       lut_rgb = '{8'hFF, 8'h80, 8'h80};
            4'hE:       lut_rgb = '{8'hFF, 8'hC0, 8'hC0};
            default:    lut_rgb = '{8'hFF, 8'hFF, 8'hFF};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] mode_reg;
    logic [7:0] input_reg;
    logic [7:0] output_reg;

    wire hit_mode   = reg_write && (reg_addr == `MODE_REG_ADDR);
    wire hit_input  = reg_write && (reg_addr == `INPUT_REG_ADDR);
    wire hit_output = reg_write && (reg_addr == `OUTPUT_REG_ADDR);

    // Masked writes keep undefined bits at zero
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_reg   <= `MODE_REG_RESET;                    // [RULE1]
            input_reg  <= `INPUT_REG_RESET;
            output_reg <= `OUTPUT_REG_RESET;
        end else begin
            if (hit_mode)
                mode_reg <= reg_wdata & `MODE_REG_WMASK;      // [RULE15]
            if (hit_input)
                input_reg <= reg_wdata & `INPUT_REG_WMASK;
            if (hit_output)
                output_reg <= reg_wdata & `OUTPUT_REG_WMASK;  // [RULE15]
        end
    end

    // Read mux; unmapped addresses read zero
    wire [7:0] next_rdata = (reg_addr == `MODE_REG_ADDR)   ? mode_reg   :
                            (reg_addr == `INPUT_REG_ADDR)  ? input_reg  :
                            (reg_addr == `OUTPUT_REG_ADDR) ? output_reg : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    wire       buf_on    = mode_reg[`BUF_ON_BIT];
    wire [2:0] color_sel = mode_reg[`COLOR_MSB:`COLOR_LSB];
    wire [1:0] speed     = mode_reg[`SPEED_MSB:`SPEED_LSB];
    wire [2:0] gain_code = input_reg[`GAIN_MSB:`GAIN_LSB];
    wire [2:0] agc_code  = input_reg[`AGC_MSB:`AGC_LSB];
    wire       man_start = input_reg[`MAN_START_BIT];
    wire       dis_start = input_reg[`DIS_START_BIT];
    wire [2:0] ampl_code = output_reg[`AMPL_MSB:`AMPL_LSB];

    assign audio_buf_en   = buf_on;                                             // [RULE1]
    assign buffer_gain_db = 8'(`GAIN_BASE_DB + `GAIN_STEP_DB * int'(gain_code)); // [RULE4]
    assign agc_mode       = (agc_code == 3'h0) ? AGC_OFF :                      // [RULE5]
                            (agc_code == 3'h1) ? AGC_LOW_CUT :
                            (agc_code[2:1] == 2'h1) ? AGC_CURVE_A :             // [RULE6]
                            (agc_code[2:1] == 2'h2) ? AGC_CURVE_B : AGC_CURVE_C;
    assign agc_fast_decay = agc_code[0] && (agc_code[2:1] != 2'h0);             // [RULE6]

    assign sink_group_b_sync  = output_reg[`SYNC_B_BIT];                        // [RULE11]
    assign sink_group_a_sync  = output_reg[`SYNC_A_BIT];                        // [RULE12]
    assign converter_500k_run = sink_group_a_sync || sink_group_b_sync;         // [RULE11] [RULE12]

    ////////////////////////////////////////////////////////////////////////////
    // Precharge of the coupling capacitor
    logic        buf_on_d;
    logic [11:0] pre_cnt;
    wire         buf_start = buf_on && !buf_on_d;

    // Timer restarts on each buffer enable; buffer off aborts it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            buf_on_d <= 1'b0;
            pre_cnt  <= 12'h000;
        end else begin
            buf_on_d <= buf_on;
            if (!buf_on)
                pre_cnt <= 12'h000;
            else if (buf_start)
                pre_cnt <= 12'(`PRECHARGE_CYCLES);            // [RULE7]
            else if (pre_cnt != 12'h000)
                pre_cnt <= pre_cnt - 12'h001;
        end
    end

    assign precharge_en = dis_start ? 1'b0 :                  // [RULE9]
                          man_start ? buf_on :                // [RULE8]
                          (pre_cnt != 12'h000);               // [RULE7]

    ////////////////////////////////////////////////////////////////////////////
    // Amplitude envelope
    agc_if agc ();

    assign agc.sample_valid = audio_amp_valid;
    assign agc.sample       = audio_amp;
    assign agc.enable       = buf_on && (agc_code != 3'h0);
    assign agc.fast_decay   = agc_fast_decay;
    assign agc_level        = agc.level;

    agc_envelope #(
        .SLOW_DECAY_CYCLES (SLOW_DECAY_CYCLES),
        .FAST_DECAY_CYCLES (FAST_DECAY_CYCLES)
    ) u_envelope (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .agc     (agc)
    );

    // Low-cut mode blanks noise; curves are applied in the analogue path
    wire [3:0] shaped = (agc_code == 3'h1 && audio_amp < `LOW_CUT_LEVEL) ? 4'h0 :  // [RULE5]
                        audio_amp;

    ////////////////////////////////////////////////////////////////////////////
    // Persistence hold: a louder sample always wins, quieter ones wait
    logic [3:0]  held;
    logic [23:0] hold_cnt;
    wire  [23:0] hold_len = (speed == 2'h0) ? 24'h000000 :
                            (speed == 2'h1) ? HOLD_UNIT_CYCLES[23:0] :
                            (speed == 2'h2) ? 24'(HOLD_UNIT_CYCLES * 2) :
                                              24'(HOLD_UNIT_CYCLES * 4);  // [RULE3]
    wire         take     = audio_amp_valid && (shaped >= held || hold_cnt == 24'h000000);

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !buf_on) begin
            held     <= 4'h0;
            hold_cnt <= 24'h000000;
        end else if (take) begin
            held     <= shaped;                               // [RULE3]
            hold_cnt <= hold_len;
        end else if (hold_cnt != 24'h000000) begin
            hold_cnt <= hold_cnt - 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Colour mapping and sink drive
    wire [7:0] mono  = {held, held};
    wire rgb_t col   = (color_sel == 3'h0) ? lut_rgb(held) :          // [RULE13]
                       rgb_t'{color_sel[2] ? mono : 8'h00,             // [RULE2]
                         color_sel[1] ? mono : 8'h00,
                         color_sel[0] ? mono : 8'h00};
    wire [7:0] r_out = scale(col.r, ampl_code);
    wire [7:0] g_out = scale(col.g, ampl_code);
    wire [7:0] b_out = scale(col.b, ampl_code);

    // Disabled groups sink nothing
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sink_a0 <= 8'h00;
            sink_a1 <= 8'h00;
            sink_a2 <= 8'h00;
            sink_b0 <= 8'h00;
            sink_b1 <= 8'h00;
            sink_b2 <= 8'h00;
        end else begin
            sink_b0 <= sink_group_b_sync ? r_out : 8'h00;    // [RULE11]
            sink_b1 <= sink_group_b_sync ? g_out : 8'h00;
            sink_b2 <= sink_group_b_sync ? b_out : 8'h00;
            sink_a0 <= sink_group_a_sync ? r_out : 8'h00;    // [RULE12]
            sink_a1 <= sink_group_a_sync ? g_out : 8'h00;
            sink_a2 <= sink_group_a_sync ? b_out : 8'h00;
        end
    end
endmodule

/* verilog/audio_led_pkg.sv */
package audio_led_pkg;

    typedef enum logic [2:0] {
        AGC_OFF,
        AGC_LOW_CUT,
        AGC_CURVE_A,
        AGC_CURVE_B,
        AGC_CURVE_C
    } agc_mode_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgb_t;

endpackage
